/* design/vbc_pkg.sv */
// Package for the VCO band calibration configuration block.
// Holds register offsets, field layouts, codes and timing constants.
package vbc_pkg;
  // Register byte offsets (32-bit words)
  localparam logic [3:0] OFF_CTRL   = 4'h0;  // Select, method, high-ref, go
  localparam logic [3:0] OFF_SCALE  = 4'h4;  // Manual scale word
  localparam logic [3:0] OFF_FIXA   = 4'h8;  // Fixed setup word A
  localparam logic [3:0] OFF_FIXB   = 4'hc;  // Fixed setup word B

  // Control field positions
  localparam int CTL_SEL_LSB  = 0;   // cal_clock_select [2:0]
  localparam int CTL_METH_LSB = 4;   // band_search_method [5:4]
  localparam int CTL_HREF_BIT = 8;   // manual_cal_high_ref
  localparam int CTL_GO_BIT   = 12;  // Start calibration (write only)
  localparam int STS_BUSY_BIT = 16;  // Engine busy (read)
  localparam int STS_DONE_BIT = 17;  // Engine done (read)
  localparam int STS_ERR_BIT  = 18;  // Reserved method used (read)
  localparam int STS_BAND_LSB = 24;  // Found band

  // Codes
  localparam logic [2:0] SEL_MANUAL  = 3'h4;
  localparam logic [1:0] METH_LINEAR = 2'h1;
  localparam logic [1:0] METH_MIXED  = 2'h2;

  // Reset values
  localparam logic [2:0]  SEL_RST   = 3'h0;
  localparam logic [1:0]  METH_RST  = 2'h1;
  localparam logic [11:0] SCALE_RST = 12'h000;

  // Per-comparison settle times; high-ref bit lengthens it
  localparam int CLK_MHZ        = 40;
  localparam int SETTLE_NS      = 200;
  localparam int SETTLE_HREF_NS = 400;
  localparam int SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_HREF_CYC = (SETTLE_HREF_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {VBC_IDLE, VBC_BIN, VBC_LIN, VBC_DONE} vbc_state_t;
endpackage : vbc_pkg

/* design/vbc_top.sv */
// VCO band calibration configuration and search engine.
// Assumes an Avalon-MM master on REF_CLK_I and a band comparator input
// that reports whether the VCO is above target for the tried band.
//
// How it works
// R1: Host loads scale word in manual mode
// R2: Scale equals 16 times fref over constant
// R3: High-ref bit only above 40 MHz
// R4: High-ref bit lengthens calibration step timing
// R5: Method codes: 1 linear, 2 mixed
// R6: Linear search steps bands one by one
// R7: Mixed: binary narrowing, then linear finish
// R8: Mixed only on allowed parts, fref>=8MHz
// R9: Linear quick for small, mixed for large
// R10: Host writes fixed setup word A
// R11: Host still loads fixed setup word B
// R12: Select code 4 uses manual scale
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module vbc_top #(
  parameter int BAND_W  = 6,
  parameter int LIN_WIN = 4
) (
  // Clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              ARST_N_I,
  // Avalon-MM slave
  input  wire logic [3:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  // Band comparator and calibration outputs
  input  wire logic              VCO_ABOVE_I,
  output logic      [BAND_W-1:0] VCO_BAND_O,
  output logic      [11:0]       CAL_SCALE_O,
  output logic                   CAL_BUSY_O
);
  initial begin
    if (BAND_W < 2 || BAND_W > 8 || LIN_WIN < 1) begin
      $error("vbc_top: unsupported parameters");
    end
  end

  localparam logic [7:0] SET_HI = 8'(vbc_pkg::SETTLE_HREF_CYC);
  localparam logic [7:0] SET_LO = 8'(vbc_pkg::SETTLE_CYC);
  localparam logic [BAND_W-1:0] BAND_MAX = '1;
  localparam logic [BAND_W-1:0] WIN = BAND_W'(LIN_WIN);

  logic [2:0]        sel_r;
  logic [1:0]        meth_r;
  logic              href_r;
  logic [11:0]       scale_r;
  logic [31:0]       fixa_r;
  logic [31:0]       fixb_r;
  logic              go_r;
  logic              err_r;
  logic              done_r;
  logic              ack_r;
  vbc_pkg::vbc_state_t state_r;
  logic [BAND_W-1:0] band_r;
  logic [BAND_W-1:0] step_r;
  logic [7:0]        wait_r;
  logic              req;
  logic              wr_ctl;
  logic [31:0]       ctl_rd;

  // One wait cycle per access; answer on the second edge
  assign req    = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
  // Writes land on the edge where waitrequest is seen low, not before
  assign wr_ctl = AVS_WRITE_I & ack_r & AVS_ADDRESS_I == vbc_pkg::OFF_CTRL
                  & AVS_BYTEENABLE_I[0];

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= ~req;
    end
  end

  // Configuration writes, byte lanes honoured
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sel_r   <= vbc_pkg::SEL_RST;
      meth_r  <= vbc_pkg::METH_RST;
      href_r  <= 1'b0;
      scale_r <= vbc_pkg::SCALE_RST;
      fixa_r  <= 32'h0;
      fixb_r  <= 32'h0;
    end else if (AVS_WRITE_I && ack_r) begin
      unique case (AVS_ADDRESS_I)
        vbc_pkg::OFF_CTRL: begin
          if (AVS_BYTEENABLE_I[0]) begin
            sel_r  <= AVS_WRITEDATA_I[vbc_pkg::CTL_SEL_LSB +: 3];
            meth_r <= AVS_WRITEDATA_I[vbc_pkg::CTL_METH_LSB +: 2];
          end
          // R4 high-ref bit stored
          if (AVS_BYTEENABLE_I[1]) begin
            href_r <= AVS_WRITEDATA_I[vbc_pkg::CTL_HREF_BIT];
          end
        end
        // R1 manual scale word
        vbc_pkg::OFF_SCALE: begin
          if (AVS_BYTEENABLE_I[0]) scale_r[7:0] <= AVS_WRITEDATA_I[7:0];
          if (AVS_BYTEENABLE_I[1]) scale_r[11:8] <= AVS_WRITEDATA_I[11:8];
        end
        // R10 fixed word A
        vbc_pkg::OFF_FIXA: begin
          for (int i = 0; i < 4; i++) begin
            if (AVS_BYTEENABLE_I[i]) fixa_r[8*i +: 8] <= AVS_WRITEDATA_I[8*i +: 8];
          end
        end
        // R11 fixed word B
        vbc_pkg::OFF_FIXB: begin
          for (int i = 0; i < 4; i++) begin
            if (AVS_BYTEENABLE_I[i]) fixb_r[8*i +: 8] <= AVS_WRITEDATA_I[8*i +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // Start pulse; reserved method codes refuse to start
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      go_r  <= 1'b0;
      err_r <= 1'b0;
    end else begin
      go_r <= wr_ctl & AVS_WRITEDATA_I[vbc_pkg::CTL_GO_BIT] & ~AVS_BYTEENABLE_I[1]
              ? 1'b0 : wr_ctl & AVS_WRITEDATA_I[vbc_pkg::CTL_GO_BIT];
      // R5 reserved codes flagged
      if (go_r) begin
        err_r <= meth_r != vbc_pkg::METH_LINEAR && meth_r != vbc_pkg::METH_MIXED;
      end
    end
  end

  // Band search engine
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_r <= vbc_pkg::VBC_IDLE;
      band_r  <= '0;
      step_r  <= '0;
      wait_r  <= 8'h00;
      done_r  <= 1'b0;
    end else if (wait_r != 8'h00) begin
      wait_r <= wait_r - 8'h01;
    end else begin
      unique case (state_r)
        vbc_pkg::VBC_IDLE: begin
          if (go_r) begin
            done_r <= 1'b0;
            // R4 longer settle with high-ref
            wait_r <= href_r ? SET_HI : SET_LO;
            // R7 mixed starts at mid band
            if (meth_r == vbc_pkg::METH_MIXED) begin
              state_r <= vbc_pkg::VBC_BIN;
              band_r  <= BAND_W'(1) << (BAND_W - 1);
              step_r  <= BAND_W'(1) << (BAND_W - 2);
            // R6 linear starts at band zero
            end else if (meth_r == vbc_pkg::METH_LINEAR) begin
              state_r <= vbc_pkg::VBC_LIN;
              band_r  <= '0;
            end
          end
        end
        // R7 divide and conquer narrowing
        vbc_pkg::VBC_BIN: begin
          wait_r <= href_r ? SET_HI : SET_LO;
          if (step_r < WIN) begin
            state_r <= vbc_pkg::VBC_LIN;
            band_r  <= (band_r > WIN) ? band_r - WIN : '0;
          end else begin
            band_r <= VCO_ABOVE_I ? band_r - step_r : band_r + step_r;
            step_r <= step_r >> 1;
          end
        end
        // R6 consecutive band steps
        vbc_pkg::VBC_LIN: begin
          if (VCO_ABOVE_I || band_r == BAND_MAX) begin
            state_r <= vbc_pkg::VBC_DONE;
          end else begin
            band_r <= band_r + 1'b1;
            wait_r <= href_r ? SET_HI : SET_LO;
          end
        end
        vbc_pkg::VBC_DONE: begin
          done_r  <= 1'b1;
          state_r <= vbc_pkg::VBC_IDLE;
        end
      endcase
    end
  end

  // R12 manual select drives scale word, else zero
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CAL_SCALE_O <= 12'h000;
    end else begin
      CAL_SCALE_O <= sel_r == vbc_pkg::SEL_MANUAL ? scale_r : 12'h000;
    end
  end

  // Outputs registered
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      VCO_BAND_O <= '0;
      CAL_BUSY_O <= 1'b0;
    end else begin
      VCO_BAND_O <= band_r;
      CAL_BUSY_O <= state_r != vbc_pkg::VBC_IDLE;
    end
  end

  // Read mux
  always_comb begin
    ctl_rd = 32'h0;
    ctl_rd[vbc_pkg::CTL_SEL_LSB +: 3]  = sel_r;
    ctl_rd[vbc_pkg::CTL_METH_LSB +: 2] = meth_r;
    ctl_rd[vbc_pkg::CTL_HREF_BIT]      = href_r;
    ctl_rd[vbc_pkg::STS_BUSY_BIT]      = state_r != vbc_pkg::VBC_IDLE;
    ctl_rd[vbc_pkg::STS_DONE_BIT]      = done_r;
    ctl_rd[vbc_pkg::STS_ERR_BIT]       = err_r;
    ctl_rd[vbc_pkg::STS_BAND_LSB +: BAND_W] = band_r;
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= 32'h0;
    end else if (AVS_READ_I && req) begin
      unique case (AVS_ADDRESS_I)
        vbc_pkg::OFF_CTRL:  AVS_READDATA_O <= ctl_rd;
        vbc_pkg::OFF_SCALE: AVS_READDATA_O <= {20'h0, scale_r};
        vbc_pkg::OFF_FIXA:  AVS_READDATA_O <= fixa_r;
        vbc_pkg::OFF_FIXB:  AVS_READDATA_O <= fixb_r;
        default:            AVS_READDATA_O <= 32'h0;
      endcase
    end
  end
endmodule : vbc_top

/* sim/vbc_top_checker.sv */
// Port checker for the band calibration top, bound below.
// Assumes control writes that start a search carry lanes 0 and 1.
`timescale 1ns/1ps
module vbc_top_checker #(
  parameter int BAND_W = 6
) (
  // Clock, reset and bus
  input wire logic              REF_CLK_I,
  input wire logic              ARST_N_I,
  input wire logic [3:0]        AVS_ADDRESS_I,
  input wire logic              AVS_WRITE_I,
  input wire logic [31:0]       AVS_WRITEDATA_I,
  input wire logic [3:0]        AVS_BYTEENABLE_I,
  input wire logic              AVS_WAITREQUEST_O,
  // Engine outputs
  input wire logic [BAND_W-1:0] VCO_BAND_O,
  input wire logic [11:0]       CAL_SCALE_O,
  input wire logic              CAL_BUSY_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // Accepted start request and its method code
  wire go_w = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0
    && AVS_BYTEENABLE_I[1:0] == 2'h3 && AVS_WRITEDATA_I[12];
  wire [1:0] m_w = AVS_WRITEDATA_I[5:4];
  logic lin_r;
  // Method of the running search, kept for the step check
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I)
      lin_r <= 1'b0;
    else if (go_w)
      lin_r <= (m_w == 2'h1);
  end
  property p_rsv;
    go_w && !CAL_BUSY_O && (m_w == 2'h0 || m_w == 2'h3) |=> !CAL_BUSY_O [*4];
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("search started on reserved code");
  property p_start;
    go_w && !CAL_BUSY_O && (m_w == 2'h1 || m_w == 2'h2) |-> ##[1:3] CAL_BUSY_O;
  endproperty
  a_start: assert property (p_start)
    else $error("valid start ignored");
  // Each tried band is held for at least seven cycles
  property p_settle;
    $changed(VCO_BAND_O) |=> $stable(VCO_BAND_O) [*6];
  endproperty
  a_settle: assert property (p_settle)
    else $error("band held too briefly");
  property p_lin;
    lin_r && $past(CAL_BUSY_O, 2) && $changed(VCO_BAND_O)
      |-> VCO_BAND_O == $past(VCO_BAND_O) + 1'b1;
  endproperty
  a_lin: assert property (p_lin)
    else $error("linear search skipped a band");
  property p_end;
    $rose(CAL_BUSY_O) |-> ##[1:1000] !CAL_BUSY_O;
  endproperty
  a_end: assert property (p_end)
    else $error("search did not finish");
  property p_scale;
    $changed(CAL_SCALE_O) |-> $past(AVS_WRITE_I) || $past(AVS_WRITE_I, 2);
  endproperty
  a_scale: assert property (p_scale)
    else $error("scale output moved without a write");
  c_lin: cover property ($rose(CAL_BUSY_O) && lin_r);
  c_mix: cover property ($rose(CAL_BUSY_O) && !lin_r);
  c_rsv: cover property (go_w && m_w == 2'h3);
endmodule : vbc_top_checker
bind vbc_top vbc_top_checker #(.BAND_W(BAND_W)) u_vbc_top_checker (
  .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .VCO_BAND_O(VCO_BAND_O), .CAL_SCALE_O(CAL_SCALE_O), .CAL_BUSY_O(CAL_BUSY_O));

/* sim/vbc_top_tb.sv */
// Bench for the band calibration block: registers, then searches.
// Assumes the comparator model answers against a target band.
`timescale 1ns/1ps
module vbc_top_tb;
  logic        clk, arst_n, rd, wr, wt, busy, above;
  logic [3:0]  adr, band, tgt;
  logic [11:0] scale;
  logic [31:0] wd, rdat, q;
  int          errors, n_compared, cyc, t0, t1;
  // Address, write word, expected read word
  logic [67:0] rows [6] = '{
    {4'h4, 32'h0000_00a0, 32'h0000_00a0},  // 16 x 20 MHz / 2
    {4'h4, 32'hffff_f0a0, 32'h0000_00a0},  // Upper bits dropped
    {4'h8, 32'h1234_5678, 32'h1234_5678},
    {4'hc, 32'h9abc_def0, 32'h9abc_def0},
    {4'h0, 32'h0000_0014, 32'h0000_0014},  // Manual, linear
    {4'h2, 32'hffff_ffff, 32'h0000_0000}}; // Unmapped
  vbc_top #(.BAND_W(4), .LIN_WIN(4)) u_vbc_top (
    .REF_CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wt), .VCO_ABOVE_I(above), .VCO_BAND_O(band),
    .CAL_SCALE_O(scale), .CAL_BUSY_O(busy));
  vbc_vco_model #(.BAND_W(4)) u_vbc_vco_model (
    .band_i(band), .target_i(tgt), .above_o(above));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, far above the longest search
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask : bus
  task automatic cal(input logic [1:0] m, input logic h, input logic [3:0] t,
                     output int n);
    n = cyc;
    tgt <= t;
    bus(1'b1, 4'h0, 32'h1004 | 32'(h) << 8 | 32'(m) << 4);
    repeat (4) @(negedge clk);
    chk("busy", 1, busy);
    while (busy === 1'b1 && cyc - n < 2000) @(negedge clk);
    n = cyc - n;
    bus(1'b0, 4'h0, 32'h0);
    chk("done", 1, q[17]);
    chk("band", t, q[27:24]);
  endtask : cal
  initial begin
    {arst_n, rd, wr, adr, wd, tgt} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("wait rst", 1, wt);
    chk("scale rst", 0, scale);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl rst", 32'h10, q);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][67:64], rows[i][63:32]);
      bus(1'b0, rows[i][67:64], 32'h0);
      chk("reg", rows[i][31:0], q);
    end
    @(negedge clk);
    chk("scale out", 32'h0a0, scale);
    // Reference now 61.44 MHz, so high-ref and mixed are allowed
    bus(1'b1, 4'h4, 32'h1ec);
    cal(2'h1, 1'b0, 4'h0, t0);
    cal(2'h1, 1'b0, 4'h0, t0);
    cal(2'h1, 1'b1, 4'h0, t1);
    chk("href slower", 1, t1 > t0);
    cal(2'h1, 1'b0, 4'hf, t0);
    cal(2'h2, 1'b0, 4'hf, t1);
    chk("mixed faster", 1, t1 < t0);
    // Reserved codes start nothing and flag an error
    for (int i = 0; i < 4; i += 3) begin
      bus(1'b1, 4'h0, 32'h1004 | i << 4);
      repeat (4) @(negedge clk);
      chk("rsv busy", 0, busy);
      bus(1'b0, 4'h0, 32'h0);
      chk("rsv err", 1, q[18]);
    end
    stop_test();
  end
endmodule : vbc_top_tb

/* sim/vbc_vco_model.sv */
// VCO comparator model facing the band bus of the block.
// Assumes the band bus is registered on the block's clock.
`timescale 1ns/1ps
module vbc_vco_model #(
  parameter int BAND_W = 4
) (
  // Band tried and band wanted
  input  wire logic [BAND_W-1:0] band_i,
  input  wire logic [BAND_W-1:0] target_i,
  // Comparator answer
  output logic                   above_o
);
  // Above once the tried band reaches the target
  assign above_o = (band_i >= target_i);
endmodule : vbc_vco_model
